// >>> pdb_params.svh
// Constants of the PWM post-processing block: offsets, bit positions, widths.
// Assumes inclusion by the package and the top module only.
`ifndef PDB_PARAMS_SVH
`define PDB_PARAMS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define PDB_NUM_GEN 3
`define PDB_NUM_PIN 6
`define PDB_CNT_W 16
`define PDB_DB_W 12
`define PDB_ADDR_W 8
`define PDB_NUM_ITEM 3

// ----------------------------------------
// Module register byte offsets
// ----------------------------------------
`define PDB_OFS_CTL 8'h00
`define PDB_OFS_SYNC 8'h04
`define PDB_OFS_PIN_EN 8'h08
`define PDB_OFS_PIN_INV 8'h0C
`define PDB_OFS_FLT_EN 8'h10
`define PDB_OFS_INTEN 8'h14
`define PDB_OFS_RIS 8'h18
`define PDB_OFS_ISC 8'h1C
`define PDB_OFS_STATUS 8'h20

// ----------------------------------------
// Generator register offsets, within a 0x40 block
// ----------------------------------------
`define PDB_GOFS_CTL 6'h00
`define PDB_GOFS_INTEN 6'h04
`define PDB_GOFS_RIS 6'h08
`define PDB_GOFS_ISC 6'h0C
`define PDB_GOFS_LOAD 6'h10
`define PDB_GOFS_COUNT 6'h14
`define PDB_GOFS_CMPA 6'h18
`define PDB_GOFS_CMPB 6'h1C
`define PDB_GOFS_DBCTL 6'h28
`define PDB_GOFS_DBRISE 6'h2C
`define PDB_GOFS_DBFALL 6'h30

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PDB_GC_EN 0
`define PDB_GC_UPDOWN 1
`define PDB_GC_DBGRUN 2
`define PDB_GC_LD_SYNC 3
`define PDB_GEN_CTL_W 6
`define PDB_EVT_W 6
`define PDB_TRG_LSB 8
`define PDB_FLT_BIT 16
`define PDB_EVT_ALL 6'h3F
`define PDB_EVT_DOWN 6'h2B
`define PDB_RST_WORD 32'h0000_0000

`endif

// >>> pdb_pkg.sv
// Types shared by the PWM post-processing block.
// Assumes pdb_params.svh is on the include path.
`include "pdb_params.svh"

package pdb_pkg;

  typedef logic [`PDB_CNT_W-1:0] pdb_cnt_t;
  typedef logic [`PDB_DB_W-1:0] pdb_db_t;

  // Bit 0 is zero, bit 5 is match B down
  typedef struct packed {
    logic b_dn;
    logic b_up;
    logic a_dn;
    logic a_up;
    logic load;
    logic zero;
  } pdb_evt_s;

  typedef struct packed {
    logic [`PDB_GEN_CTL_W-1:0] ctl;
    logic [`PDB_EVT_W-1:0] inten;
    logic [`PDB_EVT_W-1:0] trgen;
    logic [`PDB_EVT_W-1:0] ris;
    pdb_cnt_t [`PDB_NUM_ITEM-1:0] act;
    pdb_cnt_t [`PDB_NUM_ITEM-1:0] pend_val;
    logic [`PDB_NUM_ITEM-1:0] pend;
    logic arm;
    logic db_en;
    pdb_db_t rise;
    pdb_db_t fall;
    pdb_db_t cnt_a;
    pdb_db_t cnt_b;
    logic out_a;
    logic out_b;
    logic halt;
  } pdb_gen_s;

  typedef struct packed {
    pdb_gen_s [`PDB_NUM_GEN-1:0] gen;
    logic [`PDB_NUM_PIN-1:0] pin_en;
    logic [`PDB_NUM_PIN-1:0] pin_inv;
    logic [`PDB_NUM_PIN-1:0] flt_en;
    logic [`PDB_NUM_GEN-1:0] gen_inten;
    logic flt_inten;
    logic flt_ris;
    logic [2:0] flt_sync;
    logic flt_lvl;
    logic [31:0] rdata;
    logic [`PDB_NUM_GEN-1:0] cnt_rst;
    logic [`PDB_NUM_GEN-1:0] trig;
    logic [`PDB_NUM_PIN-1:0] pins;
    logic irq;
  } pdb_state_s;

endpackage : pdb_pkg

// >>> pdb_pwm_ctrl.sv
// PWM post-processing: dead band, event selection, updates, fault, stall, pin stage.
// Assumes counters, comparators and edge actions live outside and feed raw signals and events.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "pdb_params.svh"

// What this block does
// - Dead band off: both raw signals pass unchanged.
// - Dead band on: second raw signal ignored, pair built from first.
// - First output follows input, rising edge delayed by rise count.
// - Second output is inverted input, rising edge delayed by fall count.
// - Pair active high, never both high, both low only in delays.
// - Any chosen set of counter events raises the interrupt.
// - Separate event selection emits ADC trigger pulses.
// - Interrupt and trigger use raw events, not dead-band edges.
// - Sync register resets any chosen counters on one edge.
// - Immediate mode: new value applied at next counter zero, or next clock while the generator is disabled.
// - Sync mode: value held until global update, then applied at zero, or next clock while the generator is disabled.
// - Load and each comparator pick their update mode separately.
// - Sync update works without counter synchronisation.
// - Fault forces each fault-enabled output inactive.
// - Fault onset can raise the interrupt.
// - Stall: halt at zero, or keep running, per generator.
// - Stall never raises the interrupt.
// - One enable register gates all six pins.
// - Per-pin inversion, active high by default.
// - Software writes control zero, programs, then enables.
// - Counter runs once enable set; pins after enable bits written.
module pdb_pwm_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [`PDB_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [`PDB_NUM_GEN-1:0] i_raw_a,
  input wire logic [`PDB_NUM_GEN-1:0] i_raw_b,
  input wire pdb_pkg::pdb_evt_s [`PDB_NUM_GEN-1:0] i_evt,
  input wire pdb_pkg::pdb_cnt_t [`PDB_NUM_GEN-1:0] i_count,
  input wire logic i_fault,
  input wire logic i_dbg_stall,
  output logic [`PDB_NUM_PIN-1:0] o_pwm,
  output logic [`PDB_NUM_GEN-1:0] o_adc_trig,
  output logic o_irq,
  output logic [`PDB_NUM_GEN-1:0] o_cnt_reset,
  output logic [`PDB_NUM_GEN-1:0] o_cnt_run,
  output logic [`PDB_NUM_GEN-1:0] o_cnt_updown,
  output pdb_pkg::pdb_cnt_t [`PDB_NUM_GEN-1:0] o_load,
  output pdb_pkg::pdb_cnt_t [`PDB_NUM_GEN-1:0] o_cmpa,
  output pdb_pkg::pdb_cnt_t [`PDB_NUM_GEN-1:0] o_cmpb
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic gen_hit(input logic [`PDB_ADDR_W-1:0] a, input int g);
    return a[7:6] == 2'(g + 1);
  endfunction : gen_hit

  // Item 0 load, 1 comparator A, 2 comparator B
  function automatic logic [5:0] item_ofs(input int k);
    logic [5:0] r;
    r = `PDB_GOFS_CMPB;
    if (k == 0) r = `PDB_GOFS_LOAD;
    else if (k == 1) r = `PDB_GOFS_CMPA;
    return r;
  endfunction : item_ofs

  // Count-down mode has no up-count comparator events
  function automatic logic [`PDB_EVT_W-1:0] evt_mask(input pdb_pkg::pdb_evt_s e, input logic updown);
    return e & (updown ? `PDB_EVT_ALL : `PDB_EVT_DOWN);
  endfunction : evt_mask

  pdb_pkg::pdb_state_s s_ff;
  pdb_pkg::pdb_state_s nxt_state;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_state = s_ff;
    nxt_state.rdata = `PDB_RST_WORD;
    nxt_state.cnt_rst = '0;
    nxt_state.trig = '0;
    // Three-flop sync; level moves only when the last two agree
    nxt_state.flt_sync = {s_ff.flt_sync[1:0], i_fault};
    if (s_ff.flt_sync[1] == s_ff.flt_sync[2]) begin
      nxt_state.flt_lvl = s_ff.flt_sync[2];
    end

    if (i_wr && i_addr[7:6] == 2'h0) begin
      case (i_addr)
        `PDB_OFS_SYNC: nxt_state.cnt_rst = i_wdata[`PDB_NUM_GEN-1:0];
        `PDB_OFS_PIN_EN: nxt_state.pin_en = i_wdata[`PDB_NUM_PIN-1:0];
        `PDB_OFS_PIN_INV: nxt_state.pin_inv = i_wdata[`PDB_NUM_PIN-1:0];
        `PDB_OFS_FLT_EN: nxt_state.flt_en = i_wdata[`PDB_NUM_PIN-1:0];
        `PDB_OFS_INTEN: begin
          nxt_state.gen_inten = i_wdata[`PDB_NUM_GEN-1:0];
          nxt_state.flt_inten = i_wdata[`PDB_FLT_BIT];
        end
        `PDB_OFS_ISC: begin
          if (i_wdata[`PDB_FLT_BIT]) begin
            nxt_state.flt_ris = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Onset after the clear so a coinciding fault is kept
    if (nxt_state.flt_lvl && !s_ff.flt_lvl) begin
      nxt_state.flt_ris = 1'b1;
    end
    nxt_state.irq = nxt_state.flt_ris && nxt_state.flt_inten;

    for (int g = 0; g < `PDB_NUM_GEN; g++) begin
      // Parameter updates first so a same-cycle write stays pending
      for (int k = 0; k < `PDB_NUM_ITEM; k++) begin
        if (s_ff.gen[g].pend[k] && (!s_ff.gen[g].ctl[`PDB_GC_EN] || (i_evt[g].zero &&
            (!s_ff.gen[g].ctl[`PDB_GC_LD_SYNC + k] || s_ff.gen[g].arm)))) begin
          nxt_state.gen[g].act[k] = s_ff.gen[g].pend_val[k];
          nxt_state.gen[g].pend[k] = 1'b0;
        end
      end
      // Each generator consumes its own arm at its own zero
      if (i_evt[g].zero && s_ff.gen[g].ctl[`PDB_GC_EN]) begin
        nxt_state.gen[g].arm = 1'b0;
      end
      if (i_wr && i_addr == `PDB_OFS_CTL && i_wdata[g]) begin
        nxt_state.gen[g].arm = 1'b1;
      end

      if (i_wr && gen_hit(i_addr, g)) begin
        case (i_addr[5:0])
          `PDB_GOFS_CTL: nxt_state.gen[g].ctl = i_wdata[`PDB_GEN_CTL_W-1:0];
          `PDB_GOFS_INTEN: begin
            nxt_state.gen[g].inten = i_wdata[`PDB_EVT_W-1:0];
            nxt_state.gen[g].trgen = i_wdata[`PDB_TRG_LSB+`PDB_EVT_W-1:`PDB_TRG_LSB];
          end
          `PDB_GOFS_ISC: nxt_state.gen[g].ris = s_ff.gen[g].ris & ~i_wdata[`PDB_EVT_W-1:0];
          `PDB_GOFS_DBCTL: nxt_state.gen[g].db_en = i_wdata[0];
          `PDB_GOFS_DBRISE: nxt_state.gen[g].rise = i_wdata[`PDB_DB_W-1:0];
          `PDB_GOFS_DBFALL: nxt_state.gen[g].fall = i_wdata[`PDB_DB_W-1:0];
          default: ;
        endcase
        for (int k = 0; k < `PDB_NUM_ITEM; k++) begin
          if (i_addr[5:0] == item_ofs(k)) begin
            nxt_state.gen[g].pend_val[k] = i_wdata[`PDB_CNT_W-1:0];
            nxt_state.gen[g].pend[k] = 1'b1;
          end
        end
      end

      // Raw events, after any clear, so the set wins
      nxt_state.gen[g].ris = nxt_state.gen[g].ris | evt_mask(i_evt[g], s_ff.gen[g].ctl[`PDB_GC_UPDOWN]);
      nxt_state.trig[g] = |(evt_mask(i_evt[g], s_ff.gen[g].ctl[`PDB_GC_UPDOWN]) & s_ff.gen[g].trgen);
      // Stall is not an interrupt source
      nxt_state.irq = nxt_state.irq || (nxt_state.gen_inten[g] &&
                      |(nxt_state.gen[g].ris & nxt_state.gen[g].inten));

      // Dead band, one cycle of pipeline on every path
      if (s_ff.gen[g].db_en) begin
        nxt_state.gen[g].cnt_a = '0;
        nxt_state.gen[g].cnt_b = '0;
        if (i_raw_a[g] && s_ff.gen[g].cnt_a < s_ff.gen[g].rise) begin
          nxt_state.gen[g].cnt_a = s_ff.gen[g].cnt_a + 1'b1;
        end else if (i_raw_a[g]) begin
          nxt_state.gen[g].cnt_a = s_ff.gen[g].cnt_a;
        end
        if (!i_raw_a[g] && s_ff.gen[g].cnt_b < s_ff.gen[g].fall) begin
          nxt_state.gen[g].cnt_b = s_ff.gen[g].cnt_b + 1'b1;
        end else if (!i_raw_a[g]) begin
          nxt_state.gen[g].cnt_b = s_ff.gen[g].cnt_b;
        end
        nxt_state.gen[g].out_a = i_raw_a[g] && s_ff.gen[g].cnt_a >= s_ff.gen[g].rise;
        nxt_state.gen[g].out_b = !i_raw_a[g] && s_ff.gen[g].cnt_b >= s_ff.gen[g].fall;
      end else begin
        nxt_state.gen[g].cnt_a = '0;
        nxt_state.gen[g].cnt_b = '0;
        nxt_state.gen[g].out_a = i_raw_a[g];
        nxt_state.gen[g].out_b = i_raw_b[g];
      end

      // Halt is remembered once the counter reached zero under stall
      nxt_state.gen[g].halt = i_dbg_stall && !s_ff.gen[g].ctl[`PDB_GC_DBGRUN] &&
                              (s_ff.gen[g].halt || i_evt[g].zero);

      if (i_rd && gen_hit(i_addr, g)) begin
        case (i_addr[5:0])
          `PDB_GOFS_CTL: nxt_state.rdata[`PDB_GEN_CTL_W-1:0] = s_ff.gen[g].ctl;
          `PDB_GOFS_INTEN: begin
            nxt_state.rdata[`PDB_EVT_W-1:0] = s_ff.gen[g].inten;
            nxt_state.rdata[`PDB_TRG_LSB+`PDB_EVT_W-1:`PDB_TRG_LSB] = s_ff.gen[g].trgen;
          end
          `PDB_GOFS_RIS: nxt_state.rdata[`PDB_EVT_W-1:0] = s_ff.gen[g].ris;
          `PDB_GOFS_ISC: nxt_state.rdata[`PDB_EVT_W-1:0] = s_ff.gen[g].ris & s_ff.gen[g].inten;
          `PDB_GOFS_LOAD: nxt_state.rdata[`PDB_CNT_W-1:0] = s_ff.gen[g].pend_val[0];
          `PDB_GOFS_COUNT: nxt_state.rdata[`PDB_CNT_W-1:0] = i_count[g];
          `PDB_GOFS_CMPA: nxt_state.rdata[`PDB_CNT_W-1:0] = s_ff.gen[g].pend_val[1];
          `PDB_GOFS_CMPB: nxt_state.rdata[`PDB_CNT_W-1:0] = s_ff.gen[g].pend_val[2];
          `PDB_GOFS_DBCTL: nxt_state.rdata[0] = s_ff.gen[g].db_en;
          `PDB_GOFS_DBRISE: nxt_state.rdata[`PDB_DB_W-1:0] = s_ff.gen[g].rise;
          `PDB_GOFS_DBFALL: nxt_state.rdata[`PDB_DB_W-1:0] = s_ff.gen[g].fall;
          default: ;
        endcase
      end
    end

    // Pin stage: fault forces the inactive level, then inversion, then enable
    for (int p = 0; p < `PDB_NUM_PIN; p++) begin
      nxt_state.pins[p] = s_ff.pin_en[p] &&
        (((p % 2 == 0) ? s_ff.gen[p/2].out_a : s_ff.gen[p/2].out_b) &&
        !(s_ff.flt_lvl && s_ff.flt_en[p])) != s_ff.pin_inv[p];
    end

    if (i_rd && i_addr[7:6] == 2'h0) begin
      case (i_addr)
        `PDB_OFS_CTL: begin
          for (int g = 0; g < `PDB_NUM_GEN; g++) begin
            nxt_state.rdata[g] = s_ff.gen[g].arm;
          end
        end
        `PDB_OFS_PIN_EN: nxt_state.rdata[`PDB_NUM_PIN-1:0] = s_ff.pin_en;
        `PDB_OFS_PIN_INV: nxt_state.rdata[`PDB_NUM_PIN-1:0] = s_ff.pin_inv;
        `PDB_OFS_FLT_EN: nxt_state.rdata[`PDB_NUM_PIN-1:0] = s_ff.flt_en;
        `PDB_OFS_INTEN: begin
          nxt_state.rdata[`PDB_NUM_GEN-1:0] = s_ff.gen_inten;
          nxt_state.rdata[`PDB_FLT_BIT] = s_ff.flt_inten;
        end
        `PDB_OFS_RIS: begin
          for (int g = 0; g < `PDB_NUM_GEN; g++) begin
            nxt_state.rdata[g] = |(s_ff.gen[g].ris & s_ff.gen[g].inten);
          end
          nxt_state.rdata[`PDB_FLT_BIT] = s_ff.flt_ris;
        end
        `PDB_OFS_ISC: begin
          for (int g = 0; g < `PDB_NUM_GEN; g++) begin
            nxt_state.rdata[g] = s_ff.gen_inten[g] && |(s_ff.gen[g].ris & s_ff.gen[g].inten);
          end
          nxt_state.rdata[`PDB_FLT_BIT] = s_ff.flt_ris && s_ff.flt_inten;
        end
        `PDB_OFS_STATUS: nxt_state.rdata[0] = s_ff.flt_lvl;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_rdata = s_ff.rdata;
  assign o_pwm = s_ff.pins;
  assign o_adc_trig = s_ff.trig;
  assign o_irq = s_ff.irq;
  assign o_cnt_reset = s_ff.cnt_rst;

  for (genvar g = 0; g < `PDB_NUM_GEN; g++) begin : g_out
    // Combinational stop so the counter freezes on the zero it just hit
    assign o_cnt_run[g] = s_ff.gen[g].ctl[`PDB_GC_EN] && !(i_dbg_stall &&
      !s_ff.gen[g].ctl[`PDB_GC_DBGRUN] && (s_ff.gen[g].halt || i_evt[g].zero));
    assign o_cnt_updown[g] = s_ff.gen[g].ctl[`PDB_GC_UPDOWN];
    assign o_load[g] = s_ff.gen[g].act[0];
    assign o_cmpa[g] = s_ff.gen[g].act[1];
    assign o_cmpb[g] = s_ff.gen[g].act[2];
  end

  // ----------------------------------------
  // Checks, pins 0 and 1, dead band on generator 1, updates on generator 2
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  a_db_bypass_pair: assert property (!s_ff.gen[0].db_en |=>
    s_ff.gen[0].out_a == $past(i_raw_a[0]) && s_ff.gen[0].out_b == $past(i_raw_b[0]))
    else $error("bypass pair differs from raw inputs");
  a_db_never_both: assert property ($past(s_ff.gen[1].db_en) && s_ff.gen[1].db_en |->
    !(s_ff.gen[1].out_a && s_ff.gen[1].out_b))
    else $error("dead band pair both high");
  a_db_rise_zero: assert property (s_ff.gen[1].db_en && s_ff.gen[1].rise == '0 && i_raw_a[1] |=>
    s_ff.gen[1].out_a)
    else $error("zero rise delay added delay");
  a_db_rise_wait: assert property (s_ff.gen[1].db_en && $rose(i_raw_a[1]) && s_ff.gen[1].rise == 12'h002 |=>
    !s_ff.gen[1].out_a ##1 !s_ff.gen[1].out_a)
    else $error("rising edge came early");
  a_db_second_low: assert property ($past(s_ff.gen[1].db_en) && s_ff.gen[1].out_b |->
    !$past(i_raw_a[1]))
    else $error("second output high with input high");
  a_trig_raw_evt: assert property (o_adc_trig[0] |->
    $past(|(i_evt[0] & s_ff.gen[0].trgen)))
    else $error("trigger without selected event");
  a_irq_cause: assert property ($rose(o_irq) |->
    (s_ff.flt_ris && s_ff.flt_inten) || (|s_ff.gen_inten))
    else $error("interrupt without enabled cause");
  a_fault_force: assert property (s_ff.flt_lvl && s_ff.flt_en[0] && s_ff.pin_en[0] |=>
    o_pwm[0] == $past(s_ff.pin_inv[0]))
    else $error("faulted pin not inactive");
  a_pin_gated: assert property (!s_ff.pin_en[1] |=> !o_pwm[1])
    else $error("disabled pin driven");
  a_upd_zero_only: assert property (!$stable(o_load[2]) |->
    $past(i_evt[2].zero) || !$past(s_ff.gen[2].ctl[`PDB_GC_EN]))
    else $error("load changed away from zero");
  a_sync_hold: assert property (s_ff.gen[2].ctl[`PDB_GC_EN] && s_ff.gen[2].ctl[`PDB_GC_LD_SYNC] &&
    !s_ff.gen[2].arm |=> o_load[2] == $past(o_load[2]))
    else $error("sync load applied without update");
  // Back-to-back writes to the reset register may legally extend the pulse
  a_cnt_reset: assert property (i_wr && i_addr == `PDB_OFS_SYNC |=>
    o_cnt_reset == $past(i_wdata[2:0]) ##1 (o_cnt_reset == 3'h0 || $past(i_wr && i_addr == `PDB_OFS_SYNC)))
    else $error("counter reset not on one edge");
  a_stall_halt: assert property (i_dbg_stall && !s_ff.gen[0].ctl[`PDB_GC_DBGRUN] && i_evt[0].zero |->
    !o_cnt_run[0])
    else $error("counter ran past zero in stall");

endmodule : pdb_pwm_ctrl

// >>> pdb_gate_drv.sv
// Gate driver stand-in at the pins: counts cycles with both legs of a pair on.
// Assumes active-high pins, pair g on pins 2g and 2g+1, same clock as the block.
`timescale 1ns/10ps
module pdb_gate_drv (
  input wire logic i_ref_clk,
  input wire logic [5:0] i_pwm,
  output logic [15:0] o_shoot_cnt = 16'h0000
);
  // ----------------------------------------
  // Shoot-through watch
  // ----------------------------------------
  // Both legs on shorts the supply rail
  always @(posedge i_ref_clk) begin
    if ((i_pwm[0] && i_pwm[1]) || (i_pwm[2] && i_pwm[3]) || (i_pwm[4] && i_pwm[5])) begin
      o_shoot_cnt <= o_shoot_cnt + 16'h0001;
    end
  end
endmodule : pdb_gate_drv

// >>> pdb_pwm_ctrl_tb.sv
// Self-checking bench for the PWM post-processing block.
// Assumes the bench stands in for software, counters and the fault pin.
`timescale 1ns/10ps
module pdb_pwm_ctrl_tb;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [2:0] i_raw_a = 3'h0;
  logic [2:0] i_raw_b = 3'h0;
  pdb_pkg::pdb_evt_s [2:0] i_evt = '0;
  pdb_pkg::pdb_cnt_t [2:0] i_count = {16'h0000, 16'h0000, 16'h1234};
  logic i_fault = 1'b0;
  logic i_dbg_stall = 1'b0;
  logic [5:0] o_pwm;
  logic [2:0] o_adc_trig, o_cnt_reset, o_cnt_run, o_cnt_updown;
  logic o_irq;
  pdb_pkg::pdb_cnt_t [2:0] o_load, o_cmpa, o_cmpb;
  logic [15:0] shoot;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] d;

  always #2 i_ref_clk = ~i_ref_clk;

  pdb_pwm_ctrl u_dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_raw_a(i_raw_a), .i_raw_b(i_raw_b), .i_evt(i_evt),
    .i_count(i_count), .i_fault(i_fault), .i_dbg_stall(i_dbg_stall), .o_pwm(o_pwm),
    .o_adc_trig(o_adc_trig), .o_irq(o_irq), .o_cnt_reset(o_cnt_reset), .o_cnt_run(o_cnt_run),
    .o_cnt_updown(o_cnt_updown), .o_load(o_load), .o_cmpa(o_cmpa), .o_cmpb(o_cmpb));

  pdb_gate_drv u_drv (.i_ref_clk(i_ref_clk), .i_pwm(o_pwm), .o_shoot_cnt(shoot));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    // Step off the edge so registered answers have settled
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  // Pulse returns just after the sampling edge, answers already registered
  task automatic evt(input int g, input logic [5:0] bits);
    @(posedge i_ref_clk);
    i_evt[g] <= bits;
    @(posedge i_ref_clk);
    i_evt[g] <= 6'h00;
    #1;
  endtask : evt

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : cyc_wait

  // Edges from raw change until the pin reaches lvl
  task automatic db_edge(input int g, input logic v, input int pin, input logic lvl, input int exp);
    int n;
    @(posedge i_ref_clk);
    i_raw_a[g] <= v;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      #1 n++;
    end while (o_pwm[pin] !== lvl && n < 40);
    chk("db delay", n, exp);
  endtask : db_edge

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("pins", o_pwm, 32'h0);
    rd(8'h08); chk("pin en", d, 32'h0);
    rd(8'h40); chk("gen ctl", d, 32'h0);
    rd(8'h3C); chk("unmapped", d, 32'h0);
    rd(8'h54); chk("count", d, 32'h1234);
    $display("test reset done");
  endtask : t_reset

  task automatic t_outputs();
    @(posedge i_ref_clk);
    i_raw_a[0] <= 1'b1;
    wr(8'h08, 32'h3);
    cyc_wait(2); chk("pass", o_pwm[1:0], 32'h1);
    wr(8'h0C, 32'h2);
    cyc_wait(2); chk("invert", o_pwm[1:0], 32'h3);
    wr(8'h08, 32'h1);
    cyc_wait(2); chk("one write", o_pwm[1:0], 32'h1);
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h3);
    $display("test outputs done");
  endtask : t_outputs

  task automatic t_events();
    wr(8'h14, 32'h1);
    wr(8'h44, 32'h0801);
    evt(0, 6'h08); chk("trig", o_adc_trig, 32'h1);
    chk("irq", o_irq, 32'h0);
    cyc_wait(1); chk("trig pulse", o_adc_trig, 32'h0);
    evt(0, 6'h02); chk("trig load", o_adc_trig, 32'h0);
    evt(0, 6'h01); chk("irq zero", o_irq, 32'h1);
    chk("trig zero", o_adc_trig, 32'h0);
    rd(8'h4C); chk("isc", d, 32'h1);
    wr(8'h4C, 32'h1);
    cyc_wait(1); chk("irq clr", o_irq, 32'h0);
    wr(8'h44, 32'h0);
    $display("test events done");
  endtask : t_events

  task automatic t_fault();
    @(posedge i_ref_clk);
    i_raw_b[0] <= 1'b1;
    wr(8'h10, 32'h1);
    wr(8'h14, 32'h0001_0000);
    @(posedge i_ref_clk);
    i_fault <= 1'b1;
    cyc_wait(8); chk("fault pins", o_pwm[1:0], 32'h2);
    chk("fault irq", o_irq, 32'h1);
    rd(8'h20); chk("fault lvl", d, 32'h1);
    @(posedge i_ref_clk);
    i_fault <= 1'b0;
    cyc_wait(8); chk("fault off", o_pwm[1:0], 32'h3);
    wr(8'h1C, 32'h0001_0000);
    cyc_wait(1); chk("fault clr", o_irq, 32'h0);
    wr(8'h14, 32'h0);
    $display("test fault done");
  endtask : t_fault

  task automatic t_update();
    chk("run off", o_cnt_run[2], 32'h0);
    wr(8'hC0, 32'h1);
    chk("run on", o_cnt_run[2], 32'h1);
    wr(8'hD0, 32'h18F);
    chk("load wait", o_load[2], 32'h0);
    evt(2, 6'h01); chk("load imm", o_load[2], 32'h18F);
    wr(8'hC0, 32'hB);
    chk("updown", o_cnt_updown[2], 32'h1);
    wr(8'hD0, 32'h63);
    wr(8'hD8, 32'h12B);
    wr(8'hDC, 32'hC8);
    evt(2, 6'h01); chk("load held", o_load[2], 32'h18F);
    chk("cmpa imm", o_cmpa[2], 32'h12B);
    chk("cmpb imm", o_cmpb[2], 32'hC8);
    wr(8'h00, 32'h4);
    evt(2, 6'h01); chk("load sync", o_load[2], 32'h63);
    wr(8'h04, 32'h5);
    chk("cnt reset", o_cnt_reset, 32'h5);
    cyc_wait(1); chk("reset pulse", o_cnt_reset, 32'h0);
    $display("test update done");
  endtask : t_update

  task automatic t_stall();
    wr(8'h40, 32'h1);
    @(posedge i_ref_clk);
    i_dbg_stall <= 1'b1;
    cyc_wait(2); chk("stall run", o_cnt_run[0], 32'h1);
    evt(0, 6'h01); chk("stall halt", o_cnt_run[0], 32'h0);
    chk("stall irq", o_irq, 32'h0);
    wr(8'h40, 32'h5);
    evt(0, 6'h01); chk("keep run", o_cnt_run[0], 32'h1);
    @(posedge i_ref_clk);
    i_dbg_stall <= 1'b0;
    $display("test stall done");
  endtask : t_stall

  task automatic t_deadband();
    logic [15:0] s0;
    wr(8'h08, 32'h3C);
    wr(8'hA8, 32'h1);
    wr(8'hAC, 32'h2);
    wr(8'hB0, 32'h3);
    @(posedge i_ref_clk);
    i_raw_b[1] <= 1'b1;
    cyc_wait(8); chk("db low", o_pwm[3:2], 32'h2);
    s0 = shoot;
    db_edge(1, 1'b1, 2, 1'b1, 4);
    chk("b off", o_pwm[3], 32'h0);
    db_edge(1, 1'b0, 3, 1'b1, 5);
    chk("a off", o_pwm[2], 32'h0);
    wr(8'hAC, 32'h0);
    db_edge(1, 1'b1, 2, 1'b1, 2);
    db_edge(1, 1'b0, 2, 1'b0, 2);
    chk("shoot", shoot, {16'h0, s0});
    $display("test deadband done");
  endtask : t_deadband

  // ----------------------------------------
  // Run and watchdog
  // ----------------------------------------
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    cyc_wait(1);
    t_reset();
    t_outputs();
    t_events();
    t_fault();
    t_update();
    t_stall();
    t_deadband();
    summarize();
  end
endmodule : pdb_pwm_ctrl_tb
